// >>> logic/pmt_pkg.sv
// Shared constants and types for the PMBus target and alert interface.
package pmt_pkg;

  // Bus addressing.
  localparam logic [6:0] PMT_ARA_ADDR      = 7'h0c;
  localparam logic [6:0] PMT_FALLBACK_ADDR = 7'h7f;
  localparam logic [6:0] PMT_ADDR_BASE     = 7'h10;
  localparam logic [3:0] PMT_ADDR_CHOICES  = 4'he;

  // Command codes that the interface itself acts on.
  localparam logic [7:0] PMT_CMD_CLEAR_FAULTS      = 8'h03;
  localparam logic [7:0] PMT_CMD_STORE_DEFAULT_ALL = 8'h11;
  localparam logic [7:0] PMT_CMD_ARA_CONFIG        = 8'hd5;
  localparam int         PMT_ARA_MODE_BIT          = 4;
  localparam logic       PMT_ARA_MODE_RST          = 1'b0;

  // Linear format: fixed exponent field in the high data byte.
  localparam int PMT_EXP_MSB = 15;
  localparam int PMT_EXP_LSB = 11;

  // Packet error code: CRC-8, polynomial x^8+x^2+x+1.
  localparam logic [7:0] PMT_CRC_POLY = 8'h07;
  localparam logic [7:0] PMT_CRC_INIT = 8'h00;

  // Timing at the 100 MHz system clock.
  localparam int PMT_CLK_MHZ          = 100;
  localparam int PMT_STRETCH_MAX_US   = 35000;
  localparam int PMT_STRETCH_MAX_CYC  = PMT_STRETCH_MAX_US * PMT_CLK_MHZ;
  localparam int PMT_STRETCH_CYC      = 4;
  localparam logic [2:0] PMT_STRAP_SETTLE = 3'h4;

  // Byte-level protocol states.
  typedef enum logic [2:0] {
    PMT_IDLE,
    PMT_RX,
    PMT_ACK,
    PMT_LOAD,
    PMT_TX,
    PMT_TXACK
  } pmt_state_t;

endpackage

// >>> logic/pmt_pins_if.sv
// Sampled bus levels and bus events passed from the pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
interface pmt_pins_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, output sda, output scl_rise, output scl_fall,
               output start, output stop);
  modport snk (input scl, input sda, input scl_rise, input scl_fall,
               input start, input stop);
endinterface
`default_nettype wire

// >>> logic/pmt_pin_sync.sv
// Two-stage synchroniser for bus pins and address strap, with bus events.
`timescale 1ns/1ps
`default_nettype none
module pmt_pin_sync (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_pin_i,
  input  wire logic       sda_pin_i,
  input  wire logic [3:0] strap_i,
  output logic      [3:0] strap_o,
  pmt_pins_if.src         pins
);
  import pmt_pkg::*;

  localparam int W = 6;

  logic [W-1:0] raw;
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic         scl_prev_reg;
  logic         sda_prev_reg;

  assign raw = {strap_i, sda_pin_i, scl_pin_i};

  // Idle bus levels are high, so reset the SCL and SDA stages high; the strap stages reset low.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_sync
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          meta_reg[g] <= (g < 2) ? 1'b1 : 1'b0;
          sync_reg[g] <= (g < 2) ? 1'b1 : 1'b0;
        end else begin
          meta_reg[g] <= raw[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= sync_reg[0];
      sda_prev_reg <= sync_reg[1];
    end
  end

  assign pins.scl      = sync_reg[0];
  assign pins.sda      = sync_reg[1];
  assign pins.scl_rise = sync_reg[0] & ~scl_prev_reg;
  assign pins.scl_fall = ~sync_reg[0] & scl_prev_reg;
  assign pins.start    = sync_reg[0] & scl_prev_reg & sda_prev_reg
                         & ~sync_reg[1];
  assign pins.stop     = sync_reg[0] & scl_prev_reg & ~sda_prev_reg
                         & sync_reg[1];
  assign strap_o       = sync_reg[5:2];
endmodule
`default_nettype wire

// >>> logic/pmt_crc8.sv
// Running CRC-8 over bus bytes for the packet error code.
`timescale 1ns/1ps
`default_nettype none
module pmt_crc8 (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clear_i,
  input  wire logic       en_i,
  input  wire logic [7:0] byte_i,
  output logic      [7:0] crc_o
);
  import pmt_pkg::*;

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ PMT_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [7:0] crc_reg;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || clear_i) begin
      crc_reg <= PMT_CRC_INIT;
    end else if (en_i) begin
      crc_reg <= crc_step(crc_reg, byte_i);
    end
  end

  assign crc_o = crc_reg;
endmodule
`default_nettype wire

// >>> logic/pmt_target.sv
// PMBus/SMBus target interface with packet error code and alert response.
//
// Summary of operation
// - Works at 100 kHz and 400 kHz bus rates.
// - Clock stretch stays below 35 ms each.
// - Checks optional host PEC; accepts without it.
// - Every response ends with a PEC byte.
// - Linear exponent fixed per command, host cannot change.
// - Direct coefficient format is never supported.
// - Writes change working copy; store only on command.
// - Alert pin low from a new condition until clear faults or alert retire.
// - Alert address acknowledged only while own alert active.
// - Answer only one address at any moment.
// - Default mode: keep own address, ignore alert address.
// - Clear faults command releases the alert.
// - Config bit 4 selects alert response mode.
// - Alert response mode: ignore own address while alerting.
// - Alert address read retires alert, own address returns.
// - No arbitration among several answering targets.
// - Address from resistor strap; out of range gives 127.
// - Multi-byte words travel low byte first.
`timescale 1ns/1ps
`default_nettype none
module pmt_target #(
  parameter int STATUS_W        = 8,
  parameter int STRETCH_MAX_CYC = pmt_pkg::PMT_STRETCH_MAX_CYC
) (
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  input  wire logic                scl_pin_i,
  input  wire logic                sda_pin_i,
  output logic                     scl_o,
  output logic                     scl_oe_n_o,
  output logic                     sda_o,
  output logic                     sda_oe_n_o,
  output logic                     alert_o,
  output logic                     alert_oe_n_o,
  input  wire logic [3:0]          address_select_resistor_pin_i,
  input  wire logic [STATUS_W-1:0] status_i,
  output logic      [7:0]          cmd_o,
  input  wire logic [1:0]          wlen_i,
  input  wire logic                lin11_i,
  input  wire logic [15:0]         rd_data_i,
  output logic                     wr_strobe_o,
  output logic      [15:0]         wr_data_o,
  output logic                     store_default_o,
  output logic                     clear_faults_o,
  output logic                     pec_err_o,
  output logic                     alert_pending_o,
  output logic                     ara_mode_o,
  output logic      [6:0]          own_addr_o
);
  import pmt_pkg::*;

  // Stretch stays strictly under the longest allowed low time.
  localparam int STRETCH_LEN = (PMT_STRETCH_CYC < STRETCH_MAX_CYC)
                               ? PMT_STRETCH_CYC : STRETCH_MAX_CYC - 1;
  localparam logic [3:0] STRETCH_LAST = 4'(STRETCH_LEN - 1);

  pmt_pins_if pins ();
  logic [3:0] strap;
  logic [7:0] crc;

  pmt_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .scl_pin_i (scl_pin_i),
    .sda_pin_i (sda_pin_i),
    .strap_i   (address_select_resistor_pin_i),
    .strap_o   (strap),
    .pins      (pins)
  );

  pmt_state_t    state_reg;
  logic [7:0]    sh_reg;
  logic [3:0]    cnt_reg;
  logic [1:0]    bidx_reg;
  logic [2:0]    nwr_reg;
  logic [1:0]    rsel_reg;
  logic          is_rd_reg;
  logic          ara_txn_reg;
  logic          in_txn_reg;
  logic          cmd_seen_reg;
  logic [7:0]    cmd_reg;
  logic [15:0]   wbuf_reg;
  logic          sda_drv_reg;
  logic [3:0]    stretch_reg;
  logic          alert_reg;
  logic          alert_next;
  logic          ara_mode_reg;
  logic [STATUS_W-1:0] status_prev_reg;
  logic [6:0]    own_addr_reg;
  logic [2:0]    strap_cnt_reg;
  logic          wr_strobe_reg;
  logic [15:0]   wr_data_reg;
  logic          store_reg;
  logic          clr_reg;
  logic          pec_err_reg;

  // Address decode: the two matches are mutually exclusive by mode and alert.
  wire own_ok      = ~ara_mode_reg | ~alert_reg;
  wire match_own   = (sh_reg[7:1] == own_addr_reg) & own_ok;
  wire match_ara   = (sh_reg[7:1] == PMT_ARA_ADDR) & ara_mode_reg
                     & alert_reg & sh_reg[0];
  wire byte_done   = (state_reg == PMT_RX) & pins.scl_fall
                     & (cnt_reg == 4'h8);
  wire addr_byte   = byte_done & (bidx_reg == 2'h0);
  wire addr_hit    = match_own | match_ara;

  // Write commit at stop: without PEC the count is exact, with it the CRC
  // over the whole transaction including the PEC byte comes to zero.
  wire [2:0] wlen3    = {1'b0, wlen_i};
  wire plain_len      = (nwr_reg == wlen3);
  wire pec_len        = (nwr_reg == wlen3 + 3'h1);
  wire wr_end         = pins.stop & in_txn_reg & ~is_rd_reg & cmd_seen_reg;
  wire commit         = wr_end & (plain_len | (pec_len & (crc == 8'h00)));
  wire pec_bad        = wr_end & ~commit;
  wire is_clear       = cmd_reg == PMT_CMD_CLEAR_FAULTS;
  wire is_store       = cmd_reg == PMT_CMD_STORE_DEFAULT_ALL;
  wire is_ara_cfg     = cmd_reg == PMT_CMD_ARA_CONFIG;

  // Exponent bits come from the command's fixed value, never the host;
  // only linear data exists, no coefficient path.
  wire [15:0] wr_word = lin11_i
                        ? {rd_data_i[PMT_EXP_MSB:PMT_EXP_LSB],
                           wbuf_reg[PMT_EXP_LSB-1:0]}
                        : wbuf_reg;

  // Transmit byte selection: low byte first, PEC after the data.
  wire [1:0] dlen      = ara_txn_reg ? 2'h1 : wlen_i;
  wire       is_data   = rsel_reg < dlen;
  wire [7:0] data_byte = ara_txn_reg ? {own_addr_reg, 1'b0}
                         : (rsel_reg == 2'h0) ? rd_data_i[7:0]
                         : rd_data_i[15:8];
  wire [7:0] tx_byte   = is_data ? data_byte : crc;
  wire       load_now  = (state_reg == PMT_LOAD)
                         & (stretch_reg == STRETCH_LAST);

  // Alert retires after the alert-address byte has been clocked out.
  wire ara_retire = (state_reg == PMT_TXACK) & pins.scl_rise & ara_txn_reg
                    & (rsel_reg == 2'h1);
  wire new_fault  = |(status_i & ~status_prev_reg);
  wire crc_clear  = pins.start & ~in_txn_reg;
  wire crc_en     = byte_done | (load_now & is_data);
  wire [7:0] crc_in = byte_done ? sh_reg : tx_byte;

  pmt_crc8 u_crc (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (crc_clear),
    .en_i      (crc_en),
    .byte_i    (crc_in),
    .crc_o     (crc)
  );

  // Bit and byte sequencing follows the sampled bus clock, so any rate the
  // synchroniser can resolve works, including both standard rates.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg    <= PMT_IDLE;
      sh_reg       <= 8'h00;
      cnt_reg      <= 4'h0;
      bidx_reg     <= 2'h0;
      nwr_reg      <= 3'h0;
      rsel_reg     <= 2'h0;
      is_rd_reg    <= 1'b0;
      ara_txn_reg  <= 1'b0;
      in_txn_reg   <= 1'b0;
      cmd_seen_reg <= 1'b0;
      sda_drv_reg  <= 1'b0;
      stretch_reg  <= 4'h0;
    end else if (pins.stop) begin
      state_reg    <= PMT_IDLE;
      in_txn_reg   <= 1'b0;
      sda_drv_reg  <= 1'b0;
    end else if (pins.start) begin
      state_reg    <= PMT_RX;
      cnt_reg      <= 4'h0;
      bidx_reg     <= 2'h0;
      rsel_reg     <= 2'h0;
      in_txn_reg   <= 1'b1;
      sda_drv_reg  <= 1'b0;
      if (!in_txn_reg) begin
        nwr_reg      <= 3'h0;
        cmd_seen_reg <= 1'b0;
      end
    end else begin
      case (state_reg)
        PMT_RX: begin
          if (pins.scl_rise && cnt_reg != 4'h8) begin
            sh_reg  <= {sh_reg[6:0], pins.sda};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (bidx_reg != 2'h3) begin
              bidx_reg <= bidx_reg + 2'h1;
            end
            if (addr_byte && !addr_hit) begin
              state_reg <= PMT_IDLE;
            end else begin
              state_reg   <= PMT_ACK;
              sda_drv_reg <= 1'b1;
            end
            if (addr_byte) begin
              is_rd_reg   <= sh_reg[0];
              ara_txn_reg <= match_ara;
            end else if (!cmd_seen_reg) begin
              cmd_reg      <= sh_reg;
              cmd_seen_reg <= 1'b1;
            end else if (nwr_reg != 3'h7) begin
              nwr_reg <= nwr_reg + 3'h1;
              if (nwr_reg == 3'h0) begin
                wbuf_reg <= {8'h00, sh_reg};
              end else if (nwr_reg == 3'h1) begin
                wbuf_reg[15:8] <= sh_reg;
              end
            end
          end
        end
        PMT_ACK: begin
          if (pins.scl_fall) begin
            sda_drv_reg <= 1'b0;
            cnt_reg     <= 4'h0;
            stretch_reg <= 4'h0;
            state_reg   <= is_rd_reg ? PMT_LOAD : PMT_RX;
          end
        end
        PMT_LOAD: begin
          // The clock is held low here while read data settles.
          stretch_reg <= stretch_reg + 4'h1;
          if (load_now) begin
            sh_reg      <= tx_byte;
            sda_drv_reg <= ~tx_byte[7];
            cnt_reg     <= 4'h1;
            if (rsel_reg != 2'h3) begin
              rsel_reg <= rsel_reg + 2'h1;
            end
            state_reg   <= PMT_TX;
          end
        end
        PMT_TX: begin
          if (pins.scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_drv_reg <= 1'b0;
              state_reg   <= PMT_TXACK;
            end else begin
              sda_drv_reg <= ~sh_reg[6];
              sh_reg      <= {sh_reg[6:0], 1'b0};
              cnt_reg     <= cnt_reg + 4'h1;
            end
          end
        end
        PMT_TXACK: begin
          // The target has released data here; only the host ack is sampled, and bits sent by several targets are never compared.
          if (pins.scl_rise) begin
            if (pins.sda) begin
              state_reg <= PMT_IDLE;
            end else begin
              cnt_reg <= 4'h9;
            end
          end else if (pins.scl_fall && cnt_reg == 4'h9) begin
            stretch_reg <= 4'h0;
            state_reg   <= PMT_LOAD;
          end
        end
        default: begin
          state_reg <= PMT_IDLE;
        end
      endcase
    end
  end

  // A new condition in the same cycle as a clear wins.
  assign alert_next = new_fault
                      | (alert_reg & ~(commit & is_clear) & ~ara_retire);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      alert_reg       <= 1'b0;
      status_prev_reg <= '0;
    end else begin
      alert_reg       <= alert_next;
      status_prev_reg <= status_i;
    end
  end

  // Settings apply to the working copy; storage is only signalled on the
  // store command, never as a side effect of an ordinary write.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ara_mode_reg    <= PMT_ARA_MODE_RST;
      wr_strobe_reg   <= 1'b0;
      wr_data_reg     <= 16'h0000;
      store_reg       <= 1'b0;
      clr_reg         <= 1'b0;
      pec_err_reg     <= 1'b0;
    end else begin
      wr_strobe_reg <= commit & ~is_clear & ~is_store;
      store_reg     <= commit & is_store;
      clr_reg       <= commit & is_clear;
      pec_err_reg   <= pec_bad;
      if (commit) begin
        wr_data_reg <= wr_word;
      end
      if (commit && is_ara_cfg && nwr_reg != 3'h0) begin
        ara_mode_reg <= wbuf_reg[PMT_ARA_MODE_BIT];
      end
    end
  end

  // The strap is sampled a few cycles after reset release, once the
  // synchroniser holds settled values, and then frozen.
  wire [6:0] strap_addr = (strap < PMT_ADDR_CHOICES)
                          ? PMT_ADDR_BASE + {3'h0, strap}
                          : PMT_FALLBACK_ADDR;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      strap_cnt_reg <= 3'h0;
      own_addr_reg  <= PMT_FALLBACK_ADDR;
    end else if (strap_cnt_reg != PMT_STRAP_SETTLE) begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      own_addr_reg  <= strap_addr;
    end
  end

  // Open drain: enable low pulls the wire low.
  assign scl_o           = 1'b0;
  assign scl_oe_n_o      = state_reg != PMT_LOAD;
  assign sda_o           = 1'b0;
  assign sda_oe_n_o      = ~sda_drv_reg;
  assign alert_o         = 1'b0;
  assign alert_oe_n_o    = ~alert_reg;
  assign cmd_o           = cmd_reg;
  assign wr_strobe_o     = wr_strobe_reg;
  assign wr_data_o       = wr_data_reg;
  assign store_default_o = store_reg;
  assign clear_faults_o  = clr_reg;
  assign pec_err_o       = pec_err_reg;
  assign alert_pending_o = alert_reg;
  assign ara_mode_o      = ara_mode_reg;
  assign own_addr_o      = own_addr_reg;
endmodule
`default_nettype wire

// >>> tb/pmt_target_asserts.sv
// Port assertions for the PMBus target.
`timescale 1ns/1ps
`default_nettype none
module pmt_target_asserts #(
  parameter int STATUS_W        = 8,
  parameter int STRETCH_MAX_CYC = 16
) (
  input wire logic                clk_sys_i,
  input wire logic                sys_rst_i,
  input wire logic                scl_o,
  input wire logic                scl_oe_n_o,
  input wire logic                sda_o,
  input wire logic                sda_oe_n_o,
  input wire logic                alert_o,
  input wire logic                alert_oe_n_o,
  input wire logic [STATUS_W-1:0] status_i,
  input wire logic                wr_strobe_o,
  input wire logic                store_default_o,
  input wire logic                clear_faults_o,
  input wire logic                pec_err_o,
  input wire logic                alert_pending_o,
  input wire logic                ara_mode_o,
  input wire logic [6:0]          own_addr_o
);
  logic [31:0] low_cnt_reg;
  logic [4:0]  up_cnt_reg;

  // Uptime saturates at 16, after the strap is frozen.
  always_ff @(posedge clk_sys_i) begin
    low_cnt_reg <= (sys_rst_i || scl_oe_n_o) ? 32'h0 : low_cnt_reg + 32'h1;
    up_cnt_reg  <= sys_rst_i ? 5'h0 : up_cnt_reg + {4'h0, ~up_cnt_reg[4]};
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  a_stretch_bound: assert property (
    low_cnt_reg < STRETCH_MAX_CYC) else $error("clock stretch too long");
  a_alert_set: assert property (
    !$past(sys_rst_i) && |(status_i & ~$past(status_i)) |=> alert_pending_o)
    else $error("alert not raised");
  a_alert_pin: assert property (
    alert_pending_o |-> !alert_oe_n_o) else $error("alert pin released");
  a_alert_free: assert property (
    !alert_pending_o |-> alert_oe_n_o) else $error("alert pin driven idle");
  a_clear_alert: assert property (
    clear_faults_o && $stable(status_i) ##1 $stable(status_i)
    |-> !alert_pending_o) else $error("alert not cleared");
  a_pec_nothing: assert property (
    pec_err_o |-> !wr_strobe_o && !clear_faults_o && !store_default_o)
    else $error("rejected write applied");
  a_store_once: assert property (
    store_default_o |=> !store_default_o [*4])
    else $error("store pulse repeated");
  a_addr_frozen: assert property (
    up_cnt_reg[4] |-> $stable(own_addr_o)
    && (own_addr_o inside {[7'h10:7'h1d], 7'h7f}))
    else $error("bad bus address");
  a_reset_state: assert property (
    $fell(sys_rst_i) |-> alert_oe_n_o && sda_oe_n_o && scl_oe_n_o
    && !ara_mode_o && own_addr_o == 7'h7f)
    else $error("bad reset outputs");
  a_od_zero: assert property (
    !scl_o && !sda_o && !alert_o) else $error("open drain value not low");

  c_write: cover property (wr_strobe_o);
  c_pec_err: cover property (pec_err_o);
  c_clear: cover property (clear_faults_o);
  c_ara_retire: cover property (ara_mode_o && $fell(alert_pending_o));
endmodule

bind pmt_target pmt_target_asserts #(
  .STATUS_W(STATUS_W),
  .STRETCH_MAX_CYC(STRETCH_MAX_CYC)
) u_chk (.clk_sys_i, .sys_rst_i, .scl_o, .scl_oe_n_o, .sda_o, .sda_oe_n_o,
  .alert_o, .alert_oe_n_o, .status_i, .wr_strobe_o, .store_default_o,
  .clear_faults_o, .pec_err_o, .alert_pending_o, .ara_mode_o, .own_addr_o);
`default_nettype wire

// >>> tb/pmt_host_model.sv
// Host bus master model.
`timescale 1ns/1ps
`default_nettype none
module pmt_host_model #(
  parameter int HALF_NS = 40
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_h_o,
  output logic      sda_h_o,
  output logic      hang_o
);
  initial begin
    scl_h_o = 1'b1;
    sda_h_o = 1'b1;
    hang_o  = 1'b0;
  end

  // A released clock reads low while the target stretches it.
  task automatic clk_bit(input logic b, output logic r);
    int n;
    scl_h_o = 1'b0;
    #(HALF_NS / 2) sda_h_o = b;
    #(HALF_NS / 2) scl_h_o = 1'b1;
    n = 0;
    while (scl_i !== 1'b1 && n < 2000) begin
      #1 n++;
    end
    hang_o = (n >= 2000);
    #(HALF_NS / 2) r = sda_i;
    #(HALF_NS / 2);
  endtask

  task automatic xfer(input logic [7:0] w, input logic hack,
                      output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(w[i], r[i]);
    end
    clk_bit(hack, a);
    ack = !a;
  endtask

  task automatic start();
    scl_h_o = 1'b0;
    #(HALF_NS / 2) sda_h_o = 1'b1;
    #(HALF_NS / 2) scl_h_o = 1'b1;
    #HALF_NS sda_h_o = 1'b0;
    #HALF_NS;
  endtask

  task automatic stop();
    scl_h_o = 1'b0;
    #(HALF_NS / 2) sda_h_o = 1'b0;
    #(HALF_NS / 2) scl_h_o = 1'b1;
    #HALF_NS sda_h_o = 1'b1;
    #(HALF_NS * 2);
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the PMBus target.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmt_pkg::*;
  logic        clk_sys_i, sys_rst_i, scl_pin_i, sda_pin_i, lin11_i;
  logic        scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, alert_o, alert_oe_n_o;
  logic        wr_strobe_o, store_default_o, clear_faults_o, pec_err_o;
  logic        alert_pending_o, ara_mode_o, scl_h, sda_h, hang;
  logic [3:0]  address_select_resistor_pin_i;
  logic [7:0]  status_i, cmd_o;
  logic [1:0]  wlen_i;
  logic [15:0] rd_data_i, wr_data_o, last_wr;
  logic [6:0]  own_addr_o, my_addr;
  logic [31:0] seed = 32'h16543;
  logic [7:0]  q[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n_wr = 0, n_pec = 0, n_st = 0;

  assign scl_pin_i = scl_h & (scl_oe_n_o | scl_o);
  assign sda_pin_i = sda_h & (sda_oe_n_o | sda_o);
  assign wlen_i = (cmd_o == PMT_CMD_ARA_CONFIG) ? 2'h1 :
    (cmd_o == PMT_CMD_CLEAR_FAULTS || cmd_o == PMT_CMD_STORE_DEFAULT_ALL)
    ? 2'h0 : 2'h2;

  pmt_host_model u_host (.scl_i(scl_pin_i), .sda_i(sda_pin_i),
    .scl_h_o(scl_h), .sda_h_o(sda_h), .hang_o(hang));
  pmt_target #(.STRETCH_MAX_CYC(16)) u_dut (.clk_sys_i, .sys_rst_i,
    .scl_pin_i, .sda_pin_i, .scl_o, .scl_oe_n_o, .sda_o, .sda_oe_n_o,
    .alert_o, .alert_oe_n_o, .address_select_resistor_pin_i, .status_i,
    .cmd_o, .wlen_i, .lin11_i, .rd_data_i, .wr_strobe_o, .wr_data_o,
    .store_default_o, .clear_faults_o, .pec_err_o, .alert_pending_o,
    .ara_mode_o, .own_addr_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (wr_strobe_o === 1'b1) begin
      n_wr++;
      last_wr = wr_data_o;
    end
    if (pec_err_o === 1'b1) begin
      n_pec++;
    end
    if (store_default_o === 1'b1) begin
      n_st++;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c;
    c = PMT_CRC_INIT;
    foreach (b[i]) begin
      c ^= b[i];
      repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? PMT_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [3:0] code);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    address_select_resistor_pin_i = code;
    repeat (20) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
  endtask

  // Write; pec 0 none, 1 good, 2 corrupted.
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d,
                    input int pec, output logic ak);
    logic [7:0] r;
    logic       k;
    q = '{{my_addr, 1'b0}, c};
    for (int i = 0; i < n; i++) begin
      q.push_back(d[8*i +: 8]);
    end
    if (pec > 0) begin
      q.push_back(crc8(q) ^ ((pec == 2) ? 8'hff : 8'h00));
    end
    ak = 1'b1;
    u_host.start();
    foreach (q[i]) begin
      u_host.xfer(q[i], 1'b1, r, k);
      ak &= k;
    end
    u_host.stop();
  endtask

  // Read n bytes and the PEC after a start, a repeated one when called from rdw.
  task automatic rdx(input logic [6:0] a, input int n,
                     output logic [15:0] d, output logic ak, pk);
    logic [7:0] r;
    logic       k;
    d = 16'h0000;
    q.push_back({a, 1'b1});
    u_host.start();
    u_host.xfer({a, 1'b1}, 1'b1, r, ak);
    for (int i = 0; i <= n; i++) begin
      u_host.xfer(8'hff, i == n, r, k);
      if (i < n) begin
        d[8*i +: 8] = r;
        q.push_back(r);
      end
    end
    pk = (r === crc8(q));
    u_host.stop();
  endtask

  task automatic rdw(input logic [7:0] c, output logic [15:0] d,
                     output logic ak, pk);
    logic [7:0] r;
    logic       k1, k2;
    q = '{{my_addr, 1'b0}, c};
    u_host.start();
    u_host.xfer(q[0], 1'b1, r, k1);
    u_host.xfer(c, 1'b1, r, k2);
    rdx(my_addr, 2, d, ak, pk);
    ak = ak & k1 & k2;
  endtask

  always @(posedge hang) begin
    bad_count++;
    $display("[FAIL] scl expected free seen held");
    finish_test();
  end

  initial begin
    #900000;
    bad_count++;
    $display("[FAIL] run expected done seen timeout");
    finish_test();
  end

  initial begin
    logic [15:0] d;
    logic        ak, pk;
    int          w0, e0;
    sys_rst_i = 1'b1;
    status_i = 8'h00;
    lin11_i = 1'b0;
    rd_data_i = 16'h0000;
    do_reset(4'he | 4'(rnd() & 32'h1));
    chk("fallback addr", 16'h007f, 16'(own_addr_o));
    do_reset(4'(rnd() % 14));
    my_addr = PMT_ADDR_BASE + 7'(address_select_resistor_pin_i);
    chk("strap addr", 16'(my_addr), 16'(own_addr_o));
    for (int p = 0; p < 3; p++) begin
      w0 = n_wr;
      e0 = n_pec;
      @(negedge clk_sys_i);
      lin11_i = p[0];
      rd_data_i = 16'(rnd());
      d = 16'(rnd());
      wr(8'h21, 2, d, p, ak);
      chk("pec err", 16'(e0 + (p == 2)), 16'(n_pec));
      chk("wr count", 16'(w0 + (p < 2)), 16'(n_wr));
      if (p < 2) begin
        d = p[0] ? {rd_data_i[15:11], d[10:0]} : d;
        chk("wr data", d, last_wr);
      end
    end
    chk("no store", 16'h0000, 16'(n_st));
    @(negedge clk_sys_i);
    rd_data_i = 16'(rnd());
    rdw(8'h21, d, ak, pk);
    chk("rd word", rd_data_i, d);
    chk("rd pec ack", 16'h0003, 16'({ak, pk}));
    wr(PMT_CMD_STORE_DEFAULT_ALL, 0, d, 1, ak);
    chk("store", 16'h0001, 16'(n_st));
    @(negedge clk_sys_i);
    status_i = 8'h01 << (rnd() % 8);
    repeat (3) @(negedge clk_sys_i);
    chk("alert on", 16'h0000, 16'(alert_oe_n_o));
    q = {};
    rdx(PMT_ARA_ADDR, 1, d, ak, pk);
    chk("ara ignored", 16'h0000, 16'({ak, alert_oe_n_o}));
    rdw(8'h79, d, ak, pk);
    chk("own addr", 16'h0001, 16'(ak));
    wr(PMT_CMD_CLEAR_FAULTS, 0, d, 0, ak);
    chk("alert off", 16'h0001, 16'(alert_oe_n_o));
    @(negedge clk_sys_i);
    status_i = 8'h00;
    wr(PMT_CMD_ARA_CONFIG, 1, 16'(1 << PMT_ARA_MODE_BIT), 1, ak);
    chk("ara mode", 16'h0001, 16'(ara_mode_o));
    q = {};
    rdx(PMT_ARA_ADDR, 1, d, ak, pk);
    chk("ara idle", 16'h0000, 16'(ak));
    @(negedge clk_sys_i);
    status_i = 8'h80;
    wr(8'h21, 2, d, 0, ak);
    chk("own nack", 16'h0000, 16'(ak));
    q = {};
    rdx(PMT_ARA_ADDR, 1, d, ak, pk);
    chk("ara reply", {8'h00, my_addr, 1'b0}, d);
    chk("ara ack pec", 16'h0003, 16'({ak, pk}));
    chk("alert retired", 16'h0001, 16'(alert_oe_n_o));
    wr(8'h21, 2, d, 0, ak);
    chk("own back", 16'h0001, 16'(ak));
    finish_test();
  end
endmodule
`default_nettype wire
